// ---- design/eibp_pkg.sv ----
/*
 * eibp_pkg: shared constants of the eight-bit I/O port: register offsets,
 * values after reset, peripheral function slot tables and bus codes.
 * Assumes an AXI4-Lite slave with 32-bit data, one register per word.
 */
`default_nettype none

package eibp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes
   localparam int PINS  = 8;
   localparam int SLOTS = 4;
   localparam int AW    = 6;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [AW-1:0] OFF_PIN_VALUE = 6'h00;
   localparam logic [AW-1:0] OFF_DIRECTION = 6'h04;
   localparam logic [AW-1:0] OFF_LATCH     = 6'h08;
   localparam logic [AW-1:0] OFF_ANALOG    = 6'h0C;
   localparam logic [AW-1:0] OFF_PULLUP    = 6'h10;
   localparam logic [AW-1:0] OFF_OPEN_DR   = 6'h14;
   localparam logic [AW-1:0] OFF_SLEW      = 6'h18;
   localparam logic [AW-1:0] OFF_THRESHOLD = 6'h1C;
   localparam logic [AW-1:0] OFF_PU_CTRL   = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] RST_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_LATCH     = 8'h00;
   localparam logic [7:0] RST_PULLUP    = 8'hFF;
   localparam logic [7:0] RST_OPEN_DR   = 8'h00;
   localparam logic [7:0] RST_SLEW      = 8'hFF;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic       RST_PU_DIS    = 1'b1;
   // implemented analog select bits; bit 6 is absent on this instance
   localparam logic [7:0] ANALOG_IMPL   = 8'hBF;

   ////////////////////////////////////////////////////////////////////////////
   // peripheral slots per pin, slot 0 highest priority, flat index pin*4+slot
   // pin7: programming data, dac output two, i2c/spi clock, usart sync data
   // pin6: programming clock, i2c data, usart transmit clock
   // pin5: serial data out, comparator three, capture compare three
   // pin3: capture compare two; pin2: reference clock out
   // pin1: opamp two output; pin0: capture compare one
   localparam logic [31:0] SLOT_USED  = 32'hF770_1111;
   // programming functions own the driver regardless of direction
   localparam logic [31:0] SLOT_OVRD  = 32'h1100_0000;

   ////////////////////////////////////////////////////////////////////////////
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- design/eibp_sync.sv ----
/*
 * eibp_sync: two-flop synchroniser for a vector of pad inputs.
 * Assumes each bit is asynchronous to aclk and only its level matters.
 */
`default_nettype none

module eibp_sync #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // first stage is read only by the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

`default_nettype wire

// ---- design/eibp_port.sv ----
/*
 * eibp_port: eight-bit bidirectional I/O port with registers on AXI4-Lite.
 * Assumes pads deliver both input thresholds and resolve the wire from oe.
 */
// Operation
// [R1] threshold bit 1 picks Schmitt input, 0 picks TTL, for reads and change detect
// [R2] direction bit 1 puts the pin driver in high impedance
// [R3] direction bit 0 enables the driver with output latch contents
// [R4] pin value read returns pins; write goes to the output latch
// [R5] pin value write samples pins, modifies them, stores result in latch
// [R6] direction bits drive output enables even for analog pins
// [R7] software keeps analog pins set as inputs
// [R8] analog select set makes digital reads of that pin return zero
// [R9] analog select does not affect digital outputs
// [R10] analog select bits reset to analog mode
// [R11] open-drain bit set makes the pin sink current only
// [R12] open-drain bit clear gives push-pull drive
// [R13] slew bit set limits slew rate per pin
// [R14] software changes threshold only while peripherals are disabled
// [R15] highest priority enabled function controls the pin
// [R16] pin 7 order: programming data, dac two, i2c/spi clock, usart data, latch
// [R17] some input functions override the port and join the priority order
// [R18] pull-up on only when global disable clear and pin is an input
`default_nettype none

module eibp_port (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pad inputs, both thresholds
   input  wire logic [7:0]  pin_in_schmitt,
   input  wire logic [7:0]  pin_in_ttl,
   // pad controls
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe,
   output logic      [7:0]  pin_slew_limit,
   output logic      [7:0]  pin_pullup,
   output logic      [7:0]  pin_analog,
   // selected digital input for change detection
   output logic      [7:0]  digital_input,
   // peripheral functions, flat index pin*4+slot, slot 0 highest
   input  wire logic [31:0] func_en,
   input  wire logic [31:0] func_out,
   input  wire logic [31:0] func_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // registers and internal signals
   logic [7:0]  direction_a;
   logic [7:0]  output_latch_a;
   logic [7:0]  analog_select_a;
   logic [7:0]  pullup_enable_a;
   logic [7:0]  open_drain_enable_a;
   logic [7:0]  slew_limit_a;
   logic [7:0]  input_threshold_select_a;
   logic        global_pullup_disable;
   logic [15:0] pad_sync;
   logic [7:0]  sync_schmitt;
   logic [7:0]  sync_ttl;
   logic [5:0]  aw_addr;
   logic        aw_full;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_full;
   logic        do_write;
   logic [7:0]  next_out;
   logic [7:0]  next_oe;
   logic [7:0]  won_any;
   logic [7:0]  won_ovrd;
   logic [31:0] next_rdata;
   logic        next_rerr;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // true when the offset names a register
   function automatic logic eibp_mapped(input logic [5:0] a);
      case (a)
         eibp_pkg::OFF_PIN_VALUE, eibp_pkg::OFF_DIRECTION, eibp_pkg::OFF_LATCH,
         eibp_pkg::OFF_ANALOG, eibp_pkg::OFF_PULLUP, eibp_pkg::OFF_OPEN_DR,
         eibp_pkg::OFF_SLEW, eibp_pkg::OFF_THRESHOLD, eibp_pkg::OFF_PU_CTRL: eibp_mapped = 1'b1;
         default: eibp_mapped = 1'b0;
      endcase
   endfunction

   // byte lane zero merge of a write into an eight-bit register
   function automatic logic [7:0] eibp_merge(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      eibp_merge = s[0] ? d[7:0] : old;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pad input synchroniser
   eibp_sync #(
      .WIDTH (16)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({pin_in_schmitt, pin_in_ttl}),
      .sync_out (pad_sync)
   );

   assign sync_schmitt = pad_sync[15:8];
   assign sync_ttl     = pad_sync[7:0];

   // threshold choice, analog pins read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         digital_input <= 8'h00;
      end else begin
         digital_input <= ((input_threshold_select_a & sync_schmitt) |   // R1
                           (~input_threshold_select_a & sync_ttl)) &
                          ~analog_select_a;                             // R8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write channel capture, address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full       <= 1'b0;
         aw_addr       <= 6'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end else if (!aw_full && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_full <= 1'b0;
      end else if (!w_full && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   assign do_write = aw_full && w_full;

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= eibp_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= eibp_mapped(aw_addr) ? eibp_pkg::RESP_OKAY : eibp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output latch: direct write, or read-modify-write through the pin value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_latch_a <= eibp_pkg::RST_LATCH;
      end else if (do_write && aw_addr == eibp_pkg::OFF_PIN_VALUE) begin
         output_latch_a <= eibp_merge(digital_input, w_data, w_strb); // R4 R5
      end else if (do_write && aw_addr == eibp_pkg::OFF_LATCH) begin
         output_latch_a <= eibp_merge(output_latch_a, w_data, w_strb);
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         direction_a              <= eibp_pkg::RST_DIRECTION;
         analog_select_a          <= eibp_pkg::ANALOG_IMPL;               // R10
         pullup_enable_a          <= eibp_pkg::RST_PULLUP;
         open_drain_enable_a      <= eibp_pkg::RST_OPEN_DR;
         slew_limit_a             <= eibp_pkg::RST_SLEW;
         input_threshold_select_a <= eibp_pkg::RST_THRESHOLD;
         global_pullup_disable    <= eibp_pkg::RST_PU_DIS;
      end else if (do_write) begin
         case (aw_addr)
            eibp_pkg::OFF_DIRECTION: direction_a <= eibp_merge(direction_a, w_data, w_strb);
            eibp_pkg::OFF_ANALOG:
               analog_select_a <= eibp_merge(analog_select_a, w_data, w_strb) & eibp_pkg::ANALOG_IMPL;
            eibp_pkg::OFF_PULLUP: pullup_enable_a <= eibp_merge(pullup_enable_a, w_data, w_strb);
            eibp_pkg::OFF_OPEN_DR:
               open_drain_enable_a <= eibp_merge(open_drain_enable_a, w_data, w_strb);
            eibp_pkg::OFF_SLEW: slew_limit_a <= eibp_merge(slew_limit_a, w_data, w_strb);
            eibp_pkg::OFF_THRESHOLD:
               input_threshold_select_a <= eibp_merge(input_threshold_select_a, w_data, w_strb);
            eibp_pkg::OFF_PU_CTRL: begin
               if (w_strb[0]) begin
                  global_pullup_disable <= w_data[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel, data registered one cycle after the address is taken
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      case (s_axi_araddr)
         eibp_pkg::OFF_PIN_VALUE: next_rdata[7:0] = digital_input;           // R4
         eibp_pkg::OFF_DIRECTION: next_rdata[7:0] = direction_a;
         eibp_pkg::OFF_LATCH:     next_rdata[7:0] = output_latch_a;
         eibp_pkg::OFF_ANALOG:    next_rdata[7:0] = analog_select_a;
         eibp_pkg::OFF_PULLUP:    next_rdata[7:0] = pullup_enable_a;
         eibp_pkg::OFF_OPEN_DR:   next_rdata[7:0] = open_drain_enable_a;
         eibp_pkg::OFF_SLEW:      next_rdata[7:0] = slew_limit_a;
         eibp_pkg::OFF_THRESHOLD: next_rdata[7:0] = input_threshold_select_a;
         eibp_pkg::OFF_PU_CTRL:   next_rdata[0]   = global_pullup_disable;
         default:                 next_rerr       = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= eibp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rerr ? eibp_pkg::RESP_SLVERR : eibp_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output priority: first enabled populated slot wins, latch is last
   always_comb begin
      next_out = output_latch_a;
      next_oe  = ~direction_a;                                       // R2 R3 R6 R9
      won_any  = 8'h00;
      won_ovrd = 8'h00;
      for (int p = 0; p < eibp_pkg::PINS; p++) begin
         for (int s = eibp_pkg::SLOTS - 1; s >= 0; s--) begin
            if (eibp_pkg::SLOT_USED[p*4+s] && func_en[p*4+s]) begin      // R15 R16
               won_any[p]  = 1'b1;
               won_ovrd[p] = eibp_pkg::SLOT_OVRD[p*4+s];
               next_out[p] = func_out[p*4+s];
               next_oe[p]  = eibp_pkg::SLOT_OVRD[p*4+s] ? func_oe[p*4+s] // R17
                                                        : (~direction_a[p] & func_oe[p*4+s]);
            end
         end
      end
   end

   // pad drive: open drain sinks only, push-pull drives both ways
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 8'h00;
         pin_oe  <= 8'h00;
      end else begin
         pin_out <= next_out & ~open_drain_enable_a;                  // R11 R12
         pin_oe  <= next_oe & ~(open_drain_enable_a & next_out);      // R11
      end
   end

   // slew, pull-up and analog pad controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_slew_limit <= 8'h00;
         pin_pullup     <= 8'h00;
         pin_analog     <= 8'h00;
      end else begin
         pin_slew_limit <= slew_limit_a;                              // R13
         pin_pullup     <= pullup_enable_a & direction_a & {8{~global_pullup_disable}}; // R18
         pin_analog     <= analog_select_a;                           // R8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   a_input_hiz: assert property (@(posedge aclk) disable iff (!aresetn) // R2
      $past(aresetn) |-> (pin_oe & $past(direction_a) & ~$past(won_ovrd)) == 8'h00)
      else $error("input pin driven");

   a_latch_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      $past(aresetn) && $past(direction_a[0]) == 1'b0 && !$past(won_any[0]) &&
      !$past(open_drain_enable_a[0]) |-> pin_oe[0] && pin_out[0] == $past(output_latch_a[0]))
      else $error("output pin not driven from latch");

   a_read_pins: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      s_axi_arvalid && s_axi_arready && s_axi_araddr == eibp_pkg::OFF_PIN_VALUE
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(digital_input))
      else $error("pin value read wrong");

   a_rmw_write: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      do_write && aw_addr == eibp_pkg::OFF_PIN_VALUE
      |=> output_latch_a == (w_strb[0] ? $past(w_data[7:0]) : $past(digital_input)) && s_axi_bvalid)
      else $error("pin value write not stored in latch");

   a_analog_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      $past(aresetn) |-> (digital_input & $past(analog_select_a)) == 8'h00)
      else $error("analog pin read nonzero");

   a_analog_reset: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      !$past(aresetn) |-> analog_select_a == eibp_pkg::ANALOG_IMPL)
      else $error("analog select reset value wrong");

   a_open_drain: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      $past(aresetn) |-> (pin_out & $past(open_drain_enable_a)) == 8'h00)
      else $error("open drain pin sources current");

   a_pullup_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R18
      $past(aresetn) && $past(global_pullup_disable) |-> pin_pullup == 8'h00)
      else $error("pull-up on while disabled");

   a_pin7_prio: assert property (@(posedge aclk) disable iff (!aresetn) // R16
      func_en[28] && func_en[29] && !open_drain_enable_a[7] |=> pin_out[7] == $past(func_out[28]))
      else $error("pin 7 priority wrong");

   c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
      do_write ##1 s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rready && s_axi_rresp == eibp_pkg::RESP_OKAY);
   c_periph_wins: cover property (@(posedge aclk) disable iff (!aresetn)
      won_any[7] && !direction_a[7]);

endmodule

`default_nettype wire

// ---- tb/eibp_pad_model.sv ----
/*
 * eibp_pad_model: the package pads and the wire outside them.
 * Assumes oe high means the port drives; ext_en marks a weak outside driver.
 */
`default_nettype none

module eibp_pad_model (
   // clock
   input  wire logic       aclk,
   // port side of the pads
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pullup,
   // outside world
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ttl_flip,
   // input buffers
   output logic      [7:0] pin_in_schmitt,
   output logic      [7:0] pin_in_ttl
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] level;
   logic [7:0] last;

   // a floating pin with no pull wanders every cycle
   always_ff @(posedge aclk) begin
      last <= level;
   end

   // port driver beats the weak outside driver, then the pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : ~last[i];
      end
   end

   // a mid-level pin lands on opposite sides of the two thresholds
   assign pin_in_schmitt = level;
   assign pin_in_ttl     = level ^ ttl_flip;
endmodule

`default_nettype wire

// ---- tb/eight_bit_io_port_bench.sv ----
/*
 * eight_bit_io_port_bench: register and pad tests of the eight-bit port.
 * Assumes eibp_pkg, eibp_port and eibp_pad_model are compiled first.
 */
`default_nettype none

module eight_bit_io_port_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  pin_in_schmitt, pin_in_ttl, pin_out, pin_oe, pin_slew_limit, pin_pullup, pin_analog;
   logic [7:0]  digital_input, ext_val, ext_en, ttl_flip;
   logic [31:0] func_en, func_out, func_oe;
   logic [5:0]  reg_addr [8];
   logic [7:0]  reg_init [8];
   int          fails = 0;
   int          comparisons = 0;

   ////////////////////////////////////////////////////////////////////////////
   // design and pads
   eibp_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_in_schmitt, .pin_in_ttl, .pin_out, .pin_oe, .pin_slew_limit,
      .pin_pullup, .pin_analog, .digital_input, .func_en, .func_out, .func_oe);
   eibp_pad_model pads (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .ttl_flip,
      .pin_in_schmitt, .pin_in_ttl);

   // 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks and bus cycles
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int   n;
      logic done;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done && n < 200) begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bready <= 1'b0;
            done = 1'b1;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
         end
      end
      if (!done) fails++;
   endtask

   // read with data and response compared
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
      int   n;
      logic done;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      n = 0;
      while (!done && n < 200) begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rready <= 1'b0;
            done = 1'b1;
            chk(s_axi_rdata, exp);
            chk({30'h0, s_axi_rresp}, {30'h0, er});
         end
      end
      if (!done) fails++;
   endtask

   task automatic wo(input logic [5:0] a, input logic [31:0] d);
      wr(a, d, 4'h1, eibp_pkg::RESP_OKAY);
   endtask

   task automatic ro(input logic [5:0] a, input logic [31:0] exp);
      rdc(a, exp, eibp_pkg::RESP_OKAY);
   endtask

   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      reg_addr = '{eibp_pkg::OFF_DIRECTION, eibp_pkg::OFF_LATCH, eibp_pkg::OFF_ANALOG, eibp_pkg::OFF_PULLUP,
                   eibp_pkg::OFF_OPEN_DR, eibp_pkg::OFF_SLEW, eibp_pkg::OFF_THRESHOLD, eibp_pkg::OFF_PU_CTRL};
      reg_init = '{8'hFF, 8'h00, 8'hBF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h01};
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {func_en, func_out} = '0;
      func_oe = 32'hF000_0000;
      ext_val = 8'hE7;
      ext_en = 8'hFF;
      ttl_flip = 8'h00;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      idle(2);
      // values after reset, registers and pads
      for (int i = 0; i < 8; i++) begin
         ro(reg_addr[i], {24'h0, reg_init[i]});
      end
      chk({pin_oe, pin_analog, pin_slew_limit, pin_pullup}, 32'h00BF_FF00);
      // unmapped place answers with an error and changes nothing
      rdc(6'h24, 32'h0, eibp_pkg::RESP_SLVERR);
      wr(6'h24, 32'h0, 4'h1, eibp_pkg::RESP_SLVERR);
      ro(eibp_pkg::OFF_DIRECTION, 32'hFF);
      // analog pins read zero, bit 6 stays digital
      ro(eibp_pkg::OFF_PIN_VALUE, 32'h40);
      wo(eibp_pkg::OFF_ANALOG, 32'hFF);
      ro(eibp_pkg::OFF_ANALOG, 32'hBF);
      wo(eibp_pkg::OFF_ANALOG, 32'h00);
      idle(6);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'hE7);
      // threshold select, changed while no peripheral is enabled
      ttl_flip <= 8'h0F;
      idle(6);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'hE8);
      chk({24'h0, digital_input}, 32'hE8);
      wo(eibp_pkg::OFF_THRESHOLD, 32'hFF);
      idle(6);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'hE7);
      ttl_flip <= 8'h00;
      // pin value writes go to the latch, pins follow only as outputs
      wo(eibp_pkg::OFF_PIN_VALUE, 32'h3C);
      ro(eibp_pkg::OFF_LATCH, 32'h3C);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'hE7);
      wo(eibp_pkg::OFF_DIRECTION, 32'h00);
      idle(6);
      chk({16'h0, pin_oe, pin_out}, 32'hFF3C);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'h3C);
      wo(eibp_pkg::OFF_DIRECTION, 32'hFF);
      idle(6);
      chk({24'h0, pin_oe}, 32'h00);
      wr(eibp_pkg::OFF_PIN_VALUE, 32'h0, 4'h0, eibp_pkg::RESP_OKAY);
      ro(eibp_pkg::OFF_LATCH, 32'hE7);
      // analog select leaves the drivers alone
      wo(eibp_pkg::OFF_ANALOG, 32'hFF);
      wo(eibp_pkg::OFF_DIRECTION, 32'h00);
      idle(6);
      chk({8'h0, pin_oe, pin_out, pin_analog}, 32'hFFE7BF);
      ro(eibp_pkg::OFF_PIN_VALUE, 32'h40);
      wo(eibp_pkg::OFF_ANALOG, 32'h00);
      // open drain sinks only, push-pull both ways
      wo(eibp_pkg::OFF_LATCH, 32'hF0);
      wo(eibp_pkg::OFF_OPEN_DR, 32'hFF);
      idle(2);
      chk({16'h0, pin_out, pin_oe}, 32'h000F);
      wo(eibp_pkg::OFF_OPEN_DR, 32'h00);
      idle(2);
      chk({16'h0, pin_out, pin_oe}, 32'hF0FF);
      wo(eibp_pkg::OFF_SLEW, 32'h55);
      idle(2);
      chk({24'h0, pin_slew_limit}, 32'h55);
      // pull-ups only on inputs and only with the global disable clear
      wo(eibp_pkg::OFF_DIRECTION, 32'h0F);
      wo(eibp_pkg::OFF_PU_CTRL, 32'h0);
      idle(2);
      chk({24'h0, pin_pullup}, 32'h0F);
      wo(eibp_pkg::OFF_PU_CTRL, 32'h1);
      idle(2);
      chk({24'h0, pin_pullup}, 32'h00);
      // pin 7 priority: only the winning slot drives a one
      wo(eibp_pkg::OFF_DIRECTION, 32'h00);
      wo(eibp_pkg::OFF_LATCH, 32'h00);
      for (int s = 0; s < 4; s++) begin
         func_en <= 32'hF000_0000 << s;
         func_out <= 32'h1000_0000 << s;
         idle(2);
         chk({30'h0, pin_out[7], pin_oe[7]}, 32'h3);
      end
      func_en <= 32'h0;
      idle(2);
      chk({30'h0, pin_out[7], pin_oe[7]}, 32'h1);
      // programming data overrides direction, the dac slot does not
      wo(eibp_pkg::OFF_DIRECTION, 32'hFF);
      func_en <= 32'h1000_0000;
      func_out <= 32'h1000_0000;
      idle(2);
      chk({30'h0, pin_out[7], pin_oe[7]}, 32'h3);
      func_en <= 32'h2000_0000;
      idle(2);
      chk({31'h0, pin_oe[7]}, 32'h0);
      conclude();
   end
endmodule

`default_nettype wire
